/* File: rtl/bpcfg_brownout_cfg.sv */
// brownout level 0/1 configuration registers on APB with the gain-reduction sequencer
// Overview of operation
// - level 1 release interval decodes 5..1000 ms
// - level 1 maximum attenuation bounds gain reduction
// - battery threshold 2.7 V plus 50 mV/code
// - main rail threshold 5.5 V plus 50 mV/code
// - level 1 hold 0..2000 ms, 7h unlimited
// - unlimited hold ends on hold clear
// - level 1 disable bit switches level off
// - level 0 dwell locked at zero
// - level 0 attack step -0.0625..-6 dB
// - level 0 attack interval 2.5..100 us
// - level 0 release step 0.0625..6 dB
// - level 0 release interval 5..1000 ms
// - level 0 max attenuation floor -12 dB
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module bpcfg_brownout_cfg #(
  parameter int CYCLES_PER_MS = bpcfg_pkg::NS_PER_MS / bpcfg_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // supply sensing
  input  wire logic [15:0]        supplyMv,
  input  wire logic               l0Trip,
  // gain reduction result
  output bpcfg_pkg::bpcfg_gain_t  gainOut
);
  import bpcfg_pkg::*;

  localparam int TIMER_W = 25;

  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS * 2000 >= (1 << TIMER_W)) begin : g_cfgCheck
    $error("CYCLES_PER_MS out of range");
  end

  logic [7:0]         l1RelAttnReg;
  logic [7:0]         l1ThrReg;
  logic [7:0]         l1HoldReg;
  logic [7:0]         l0DwellAtkReg;
  logic [7:0]         l0AtkRlsReg;
  logic [7:0]         l0RelAttnReg;
  logic               srcSelReg;
  logic               holdClrReg;
  logic [31:0]        prdataReg;
  logic               preadyReg;
  logic               pslverrReg;
  bpcfg_state_t       stateReg;
  logic [TIMER_W-1:0] timerReg;
  logic [19:0]        attnReg;
  logic               lastL1Reg;
  logic [31:0]        rdNext;
  logic               mappedNext;

  wire         setupPh = psel && !penable;
  wire         wrEn    = psel && penable && preadyReg && pwrite;
  wire [9:0]   regIdx  = paddr[11:2];
  wire         aligned = (paddr[1:0] == 2'b00);

  function automatic logic hit(input logic [9:0] idx);
    hit = aligned && (regIdx == idx);
  endfunction : hit

  function automatic logic [TIMER_W-1:0] msCycles(input logic [10:0] ms);
    msCycles = (ms == 11'd0) ? '0 : TIMER_W'(ms * CYCLES_PER_MS) - TIMER_W'(1);
  endfunction : msCycles

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
    merge = (old & ~mask) | (pwdata[7:0] & mask);
  endfunction : merge

  // register read mux
  always_comb begin
    rdNext     = 32'h0000_0000;
    mappedNext = aligned;
    case (regIdx)
      IDX_L1_RELEASE_ATTN:      rdNext[7:0] = l1RelAttnReg;
      IDX_L1_THRESHOLD:         rdNext[7:0] = l1ThrReg;
      IDX_L1_HOLD_DISABLE:      rdNext[7:0] = l1HoldReg;
      IDX_L0_DWELL_ATTACK_STEP: rdNext[7:0] = l0DwellAtkReg;
      IDX_L0_ATTACK_RATE_RLS:   rdNext[7:0] = l0AtkRlsReg;
      IDX_L0_RELEASE_ATTN:      rdNext[7:0] = l0RelAttnReg;
      IDX_CONTROL:              rdNext[CTRL_SRC_BIT] = srcSelReg;
      IDX_STATUS:               rdNext[4:0] = {lastL1Reg, stateReg};
      IDX_ATTENUATION:          rdNext[19:0] = attnReg;
      default:                  mappedNext = 1'b0;
    endcase
  end

  // answer prepared in setup so the access phase completes without wait
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      preadyReg  <= 1'b0;
      prdataReg  <= 32'h0000_0000;
      pslverrReg <= 1'b0;
    end else begin
      preadyReg <= setupPh;
      if (setupPh) begin
        prdataReg  <= pwrite ? 32'h0000_0000 : rdNext;
        pslverrReg <= !mappedNext;
      end else begin
        pslverrReg <= 1'b0;
      end
    end
  end

  // configuration writes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      l1RelAttnReg  <= RST_L1_RELEASE_ATTN;
      l1ThrReg      <= RST_L1_THRESHOLD;
      l1HoldReg     <= RST_L1_HOLD_DISABLE;
      l0DwellAtkReg <= RST_L0_DWELL_ATTACK_STEP;
      l0AtkRlsReg   <= RST_L0_ATTACK_RATE_RLS;
      l0RelAttnReg  <= RST_L0_RELEASE_ATTN;
      srcSelReg     <= 1'b0;
    end else if (wrEn) begin
      if (hit(IDX_L1_RELEASE_ATTN)) begin
        l1RelAttnReg <= pwdata[7:0];
      end
      if (hit(IDX_L1_THRESHOLD)) begin
        l1ThrReg <= pwdata[7:0];
      end
      if (hit(IDX_L1_HOLD_DISABLE)) begin
        l1HoldReg <= merge(l1HoldReg, WMASK_L1_HOLD_DISABLE);
      end
      if (hit(IDX_L0_DWELL_ATTACK_STEP)) begin
        l0DwellAtkReg <= merge(l0DwellAtkReg, WMASK_L0_DWELL_ATK);
      end
      if (hit(IDX_L0_ATTACK_RATE_RLS)) begin
        l0AtkRlsReg <= merge(l0AtkRlsReg, WMASK_L0_ATK_RLS);
      end
      if (hit(IDX_L0_RELEASE_ATTN)) begin
        l0RelAttnReg <= pwdata[7:0];
      end
      if (hit(IDX_CONTROL)) begin
        srcSelReg <= pwdata[CTRL_SRC_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      holdClrReg <= 1'b0;
    end else begin
      holdClrReg <= wrEn && hit(IDX_CONTROL) && pwdata[CTRL_HOLDCLR_BIT];
    end
  end

  wire [15:0] l1ThrMv = thresholdMv(l1ThrReg, srcSelReg);
  wire        l1Trip  = !l1HoldReg[DISABLE_BIT] && (l1ThrMv != 16'h0000) && (supplyMv < l1ThrMv);
  wire        tripAny = l1Trip || l0Trip;

  // reserved low codes act as -12 dB
  wire [4:0]  l0MaxCode = (l0RelAttnReg[4:0] < L0_MIN_ATTN) ? L0_MIN_ATTN : l0RelAttnReg[4:0];
  wire [19:0] target    = l1Trip ? attnUnits(l1RelAttnReg[4:0]) : attnUnits(l0MaxCode);
  wire [19:0] atkStep   = stepUnits(l0DwellAtkReg[4:1]);
  wire [19:0] rlsStep   = stepUnits(l0AtkRlsReg[4:1]);
  wire [19:0] attnUp    = (attnReg + atkStep > target) ? target : attnReg + atkStep;
  wire [TIMER_W-1:0] atkLoad =
    TIMER_W'(attackNs(l0AtkRlsReg[7:5]) / 20'(CLK_PERIOD_NS)) - TIMER_W'(1);
  // release interval of the level last attacked
  wire [TIMER_W-1:0] rlsLoad =
    msCycles(releaseMs(lastL1Reg ? l1RelAttnReg[7:5] : l0RelAttnReg[7:5]));
  // hold decode; level 0 has no hold here
  wire [TIMER_W-1:0] holdLoad = l1Trip || lastL1Reg ? msCycles(holdMs(l1HoldReg[7:5]))
                                                    : TIMER_W'(0);
  wire        holdInf = lastL1Reg && (l1HoldReg[7:5] == HOLD_INFINITE);
  wire        tick    = (timerReg == '0);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg  <= ST_IDLE;
      timerReg  <= '0;
      attnReg   <= 20'h00000;
      lastL1Reg <= 1'b0;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (tripAny) begin
            stateReg  <= ST_ATTACK;
            timerReg  <= '0;
            lastL1Reg <= l1Trip;
          end
        end
        ST_ATTACK: begin
          if (!tripAny) begin
            stateReg <= ST_HOLD;
            timerReg <= holdLoad;
          end else begin
            lastL1Reg <= l1Trip;
            if (tick) begin
              if (attnReg < target) begin
                attnReg <= attnUp;
              end
              timerReg <= atkLoad;
            end else begin
              timerReg <= timerReg - TIMER_W'(1);
            end
          end
        end
        ST_HOLD: begin
          if (tripAny) begin
            stateReg <= ST_ATTACK;
            timerReg <= '0;
          end else if (holdInf ? holdClrReg : tick) begin
            stateReg <= ST_RELEASE;
            timerReg <= rlsLoad;
          end else if (!holdInf) begin
            timerReg <= timerReg - TIMER_W'(1);
          end
        end
        ST_RELEASE: begin
          if (tripAny) begin
            stateReg <= ST_ATTACK;
            timerReg <= '0;
          end else if (tick) begin
            if (attnReg <= rlsStep) begin
              attnReg  <= 20'h00000;
              stateReg <= ST_IDLE;
            end else begin
              attnReg  <= attnReg - rlsStep;
              timerReg <= rlsLoad;
            end
          end else begin
            timerReg <= timerReg - TIMER_W'(1);
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  assign prdata          = prdataReg;
  assign pready          = preadyReg;
  assign pslverr         = pslverrReg;
  assign gainOut = '{attn: attnReg, state: stateReg, l1Active: lastL1Reg};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_holdInfWait;
    stateReg == ST_HOLD && holdInf && !tripAny;
  endsequence
  sequence s_clearSeen;
    holdClrReg && !tripAny;
  endsequence

  property p_holdClear;
    s_holdInfWait ##0 s_clearSeen |=> stateReg == ST_RELEASE;
  endproperty
  a_holdClear: assert property (p_holdClear)
    else $error("hold clear did not end unlimited hold");

  property p_holdStays;
    s_holdInfWait ##0 !holdClrReg |=> stateReg == ST_HOLD;
  endproperty
  a_holdStays: assert property (p_holdStays)
    else $error("unlimited hold left without clear");

  property p_disabled;
    l1HoldReg[DISABLE_BIT] && !l0Trip && stateReg == ST_IDLE |=> stateReg == ST_IDLE;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled level started an attack");

  property p_attnLimit;
    stateReg == ST_ATTACK && tick && tripAny && attnReg < target |=>
      attnReg <= $past(target) && attnReg > $past(attnReg);
  endproperty
  a_attnLimit: assert property (p_attnLimit)
    else $error("attack step exceeded limit or did not move");

  property p_battThr;
    !srcSelReg && l1ThrReg > BATT_LAST_CODE |-> l1ThrMv == 16'h0000;
  endproperty
  a_battThr: assert property (p_battThr)
    else $error("battery threshold above range not zero");

  property p_mainThr;
    srcSelReg && l1ThrReg <= MAIN_LAST_CODE |->
      l1ThrMv == MAIN_BASE_MV + STEP_MV * {8'h00, l1ThrReg};
  endproperty
  a_mainThr: assert property (p_mainThr)
    else $error("main rail threshold decode wrong");

  property p_dwellZero;
    pready && psel && !pwrite && hit(IDX_L0_DWELL_ATTACK_STEP) |-> prdata[7:5] == 3'h0;
  endproperty
  a_dwellZero: assert property (p_dwellZero)
    else $error("dwell field not zero");

  property p_reservedZero;
    pready && psel && !pwrite && hit(IDX_L1_HOLD_DISABLE) |-> prdata[3:0] == 4'h0;
  endproperty
  a_reservedZero: assert property (p_reservedZero)
    else $error("reserved bits not zero");

  property p_l0Floor;
    !l1Trip |-> target >= attnUnits(L0_MIN_ATTN);
  endproperty
  a_l0Floor: assert property (p_l0Floor)
    else $error("level 0 limit below 12 dB");

  property p_tripStarts;
    stateReg == ST_IDLE && tripAny |=>
      stateReg == ST_ATTACK and (tripAny && attnReg < target |=> attnReg > 20'h00000);
  endproperty
  a_tripStarts: assert property (p_tripStarts)
    else $error("trip did not start attack");

  property p_atkSpacing;
    stateReg == ST_ATTACK && tick && tripAny |=> timerReg == $past(atkLoad);
  endproperty
  a_atkSpacing: assert property (p_atkSpacing)
    else $error("attack interval reload wrong");

endmodule : bpcfg_brownout_cfg

/* File: rtl/bpcfg_pkg.sv */
// constants, types and decode functions for the brownout level 0/1 configuration slice
package bpcfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_L1_RELEASE_ATTN      = 10'h02b;
  localparam logic [9:0] IDX_L1_THRESHOLD         = 10'h02c;
  localparam logic [9:0] IDX_L1_HOLD_DISABLE      = 10'h02d;
  localparam logic [9:0] IDX_L0_DWELL_ATTACK_STEP = 10'h02e;
  localparam logic [9:0] IDX_L0_ATTACK_RATE_RLS   = 10'h02f;
  localparam logic [9:0] IDX_L0_RELEASE_ATTN      = 10'h030;
  localparam logic [9:0] IDX_CONTROL              = 10'h040;
  localparam logic [9:0] IDX_STATUS               = 10'h041;
  localparam logic [9:0] IDX_ATTENUATION          = 10'h042;

  // reset values
  localparam logic [7:0] RST_L1_RELEASE_ATTN      = 8'h38;
  localparam logic [7:0] RST_L1_THRESHOLD         = 8'h40;
  localparam logic [7:0] RST_L1_HOLD_DISABLE      = 8'h20;
  localparam logic [7:0] RST_L0_DWELL_ATTACK_STEP = 8'h02;
  localparam logic [7:0] RST_L0_ATTACK_RATE_RLS   = 8'h06;
  localparam logic [7:0] RST_L0_RELEASE_ATTN      = 8'h3e;

  // writable bit masks; the dwell field is locked at zero
  localparam logic [7:0] WMASK_L1_HOLD_DISABLE = 8'hf0;
  localparam logic [7:0] WMASK_L0_DWELL_ATK    = 8'h1e;
  localparam logic [7:0] WMASK_L0_ATK_RLS      = 8'hfe;

  // field positions
  localparam int DISABLE_BIT     = 4;
  localparam int CTRL_SRC_BIT    = 0;
  localparam int CTRL_HOLDCLR_BIT = 1;

  // decode limits
  localparam logic [7:0] BATT_LAST_CODE = 8'h38;
  localparam logic [7:0] MAIN_LAST_CODE = 8'hd2;
  localparam logic [2:0] HOLD_INFINITE  = 3'h7;
  localparam logic [4:0] L0_MIN_ATTN    = 5'h0c;

  // threshold figures in mV
  localparam logic [15:0] BATT_BASE_MV = 16'h0a8c;
  localparam logic [15:0] MAIN_BASE_MV = 16'h157c;
  localparam logic [15:0] STEP_MV      = 16'h0032;

  // attenuation held in 0.0001 dB units
  localparam logic [19:0] UNITS_PER_DB = 20'h02710;

  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS     = 1000000;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_ATTACK  = 4'h2,
    ST_HOLD    = 4'h4,
    ST_RELEASE = 4'h8
  } bpcfg_state_t;

  typedef struct packed {
    logic [19:0]  attn;
    bpcfg_state_t state;
    logic         l1Active;
  } bpcfg_gain_t;

  function automatic logic [15:0] thresholdMv(input logic [7:0] code, input logic src);
    logic [15:0] offs;
    offs = STEP_MV * {8'h00, code};
    if (!src) begin
      thresholdMv = (code <= BATT_LAST_CODE) ? BATT_BASE_MV + offs : 16'h0000;
    end else begin
      thresholdMv = (code <= MAIN_LAST_CODE) ? MAIN_BASE_MV + offs : 16'h0000;
    end
  endfunction : thresholdMv

  function automatic logic [10:0] releaseMs(input logic [2:0] code);
    case (code)
      3'h0: releaseMs = 11'd5;
      3'h1: releaseMs = 11'd10;
      3'h2: releaseMs = 11'd25;
      3'h3: releaseMs = 11'd50;
      3'h4: releaseMs = 11'd100;
      3'h5: releaseMs = 11'd250;
      3'h6: releaseMs = 11'd500;
      default: releaseMs = 11'd1000;
    endcase
  endfunction : releaseMs

  function automatic logic [10:0] holdMs(input logic [2:0] code);
    case (code)
      3'h0: holdMs = 11'd0;
      3'h1: holdMs = 11'd10;
      3'h2: holdMs = 11'd100;
      3'h3: holdMs = 11'd250;
      3'h4: holdMs = 11'd500;
      3'h5: holdMs = 11'd1000;
      default: holdMs = 11'd2000;
    endcase
  endfunction : holdMs

  function automatic logic [19:0] attackNs(input logic [2:0] code);
    case (code)
      3'h0: attackNs = 20'd2500;
      3'h1: attackNs = 20'd5000;
      3'h2: attackNs = 20'd10000;
      3'h3: attackNs = 20'd25000;
      3'h4: attackNs = 20'd50000;
      default: attackNs = 20'd100000;
    endcase
  endfunction : attackNs

  // 0.0001 dB per step; codes 2h..Eh are 0.8958 dB plus 0.3958 dB a code
  function automatic logic [19:0] stepUnits(input logic [3:0] code);
    case (code)
      4'h0: stepUnits = 20'd625;
      4'h1: stepUnits = 20'd5000;
      4'hf: stepUnits = 20'd60000;
      default: stepUnits = 20'd8958 + 20'd3958 * {16'h0000, code - 4'h2};
    endcase
  endfunction : stepUnits

  function automatic logic [19:0] attnUnits(input logic [4:0] code);
    attnUnits = UNITS_PER_DB * {15'h0000, code};
  endfunction : attnUnits

endpackage : bpcfg_pkg

/* File: verification/bpcfg_brownout_cfg_tb.sv */
// self-checking bench for the brownout level 0/1 configuration block
`timescale 1ns/10ps
module bpcfg_brownout_cfg_tb;
  import bpcfg_pkg::*;

  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] rstVal;
    logic [7:0] rdVal;
  } bpcfg_row_t;

  // short ms so hold and release finish in a few cycles
  localparam int CPM = 2;

  logic        ref_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] supplyMv;
  logic        l0Trip;
  bpcfg_gain_t gainOut;
  logic [31:0] rdData;
  logic        slvErr;
  int          err_total;
  int          comparisons;
  int          cycles;
  int          n;

  // read-back after writing all ones shows the writable bits
  bpcfg_row_t rows [6] = '{
    '{IDX_L1_RELEASE_ATTN, RST_L1_RELEASE_ATTN, 8'hff},
    '{IDX_L1_THRESHOLD, RST_L1_THRESHOLD, 8'hff},
    '{IDX_L1_HOLD_DISABLE, RST_L1_HOLD_DISABLE, 8'hf0},
    '{IDX_L0_DWELL_ATTACK_STEP, RST_L0_DWELL_ATTACK_STEP, 8'h1e},
    '{IDX_L0_ATTACK_RATE_RLS, RST_L0_ATTACK_RATE_RLS, 8'hfe},
    '{IDX_L0_RELEASE_ATTN, RST_L0_RELEASE_ATTN, 8'hff}};

  bpcfg_brownout_cfg #(.CYCLES_PER_MS(CPM)) dut (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .supplyMv(supplyMv),
    .l0Trip  (l0Trip),
    .gainOut (gainOut)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // the run should take a few thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : ba

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t no pready", $time);
    end
    rdData = prdata;
    slvErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic waitState(input logic [3:0] s, input int maxc);
    int k;
    k = 0;
    while (gainOut.state !== s && k < maxc) begin
      @(negedge ref_clk);
      k++;
    end
    check({28'h0, gainOut.state}, {28'h0, s});
  endtask : waitState

  task automatic waitAttn(input logic [19:0] v, input int maxc);
    int k;
    k = 0;
    while (gainOut.attn !== v && k < maxc) begin
      @(negedge ref_clk);
      k++;
    end
    check({12'h0, gainOut.attn}, {12'h0, v});
  endtask : waitAttn

  task automatic setSupply(input logic [15:0] v);
    @(posedge ref_clk);
    supplyMv <= v;
  endtask : setSupply

  // one threshold decode point; 16'hffff sits above every threshold
  task automatic tripCase(input logic c, input logic [7:0] code, input logic [15:0] sup,
                          input logic exp);
    xfer(ba(IDX_CONTROL), 1'b1, {31'h0, c});
    xfer(ba(IDX_L1_THRESHOLD), 1'b1, {24'h0, code});
    setSupply(sup);
    repeat (60) @(negedge ref_clk);
    check({31'h0, gainOut.state !== ST_IDLE}, {31'h0, exp});
    setSupply(16'hffff);
    waitState(ST_IDLE, 400);
  endtask : tripCase

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supplyMv = 16'hffff;
    l0Trip = 1'b0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    check({28'h0, gainOut.state}, {28'h0, ST_IDLE});
    for (int i = 0; i < 6; i++) begin
      xfer(ba(rows[i].idx), 1'b0, 32'h0);
      check(rdData, {24'h0, rows[i].rstVal});
      xfer(ba(rows[i].idx), 1'b1, 32'hffffffff);
      xfer(ba(rows[i].idx), 1'b0, 32'h0);
      check(rdData, {24'h0, rows[i].rdVal});
      xfer(ba(rows[i].idx), 1'b1, {24'h0, rows[i].rstVal});
    end
    xfer(12'h004, 1'b0, 32'h0);
    check({31'h0, slvErr}, 32'h1);
    xfer(ba(IDX_L1_RELEASE_ATTN) + 12'h001, 1'b1, 32'h0);
    check({31'h0, slvErr}, 32'h1);
    // level 1: 2 dB limit, 0 ms hold, 0.5 dB attack steps, 1.2916 dB release
    xfer(ba(IDX_L1_RELEASE_ATTN), 1'b1, 32'h02);
    xfer(ba(IDX_L1_HOLD_DISABLE), 1'b1, 32'h00);
    xfer(ba(IDX_L1_THRESHOLD), 1'b1, 32'h00);
    setSupply(16'd2699);
    waitState(ST_ATTACK, 10);
    waitAttn(20'd20000, 400);
    check({31'h0, gainOut.l1Active}, 32'h1);
    setSupply(16'd2700);
    waitState(ST_HOLD, 5);
    waitState(ST_RELEASE, 10);
    waitAttn(20'd7084, 30);
    // 5 ms at two cycles per ms gives ten cycles per release step
    n = 0;
    while (gainOut.state !== ST_IDLE && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(n, 32'd10);
    check({12'h0, gainOut.attn}, 32'h0);
    // unlimited hold stays until hold clear
    xfer(ba(IDX_L1_HOLD_DISABLE), 1'b1, 32'he0);
    setSupply(16'd2000);
    waitAttn(20'd20000, 400);
    setSupply(16'd3000);
    waitState(ST_HOLD, 5);
    repeat (300) @(negedge ref_clk);
    check({28'h0, gainOut.state}, {28'h0, ST_HOLD});
    xfer(ba(IDX_CONTROL), 1'b1, 32'h02);
    waitState(ST_IDLE, 100);
    // disabled level ignores a low supply
    xfer(ba(IDX_L1_HOLD_DISABLE), 1'b1, 32'h10);
    setSupply(16'd2000);
    repeat (100) @(negedge ref_clk);
    check({28'h0, gainOut.state}, {28'h0, ST_IDLE});
    setSupply(16'hffff);
    xfer(ba(IDX_L1_HOLD_DISABLE), 1'b1, 32'h00);
    tripCase(1'b0, 8'h00, 16'd2700, 1'b0);
    tripCase(1'b0, 8'h38, 16'd5499, 1'b1);
    tripCase(1'b0, 8'h39, 16'd100, 1'b0);
    tripCase(1'b1, 8'h00, 16'd5499, 1'b1);
    tripCase(1'b1, 8'h00, 16'd5500, 1'b0);
    tripCase(1'b1, 8'hd2, 16'd15999, 1'b1);
    tripCase(1'b1, 8'hd3, 16'd100, 1'b0);
    // level 0: reserved max code acts as 12 dB, 6 dB steps
    xfer(ba(IDX_L0_RELEASE_ATTN), 1'b1, 32'h25);
    xfer(ba(IDX_L0_DWELL_ATTACK_STEP), 1'b1, 32'h1e);
    @(posedge ref_clk);
    l0Trip <= 1'b1;
    waitAttn(20'd120000, 300);
    check({31'h0, gainOut.l1Active}, 32'h0);
    @(posedge ref_clk);
    l0Trip <= 1'b0;
    waitState(ST_IDLE, 1000);
    // attack interval code 1 is 5 us, 50 cycles
    xfer(ba(IDX_L0_DWELL_ATTACK_STEP), 1'b1, 32'h02);
    xfer(ba(IDX_L0_ATTACK_RATE_RLS), 1'b1, 32'h26);
    @(posedge ref_clk);
    l0Trip <= 1'b1;
    waitAttn(20'd5000, 60);
    n = 0;
    while (gainOut.attn !== 20'd10000 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    check(n, 32'd50);
    // reset in mid-attack returns registers and gain to reset state
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(negedge ref_clk);
    check({28'h0, gainOut.state}, {28'h0, ST_IDLE});
    check({12'h0, gainOut.attn}, 32'h0);
    @(posedge ref_clk);
    l0Trip <= 1'b0;
    nrst   <= 1'b1;
    xfer(ba(IDX_L0_ATTACK_RATE_RLS), 1'b0, 32'h0);
    check(rdData, {24'h0, RST_L0_ATTACK_RATE_RLS});
    summarize();
  end

endmodule : bpcfg_brownout_cfg_tb
